// *** pkg/pld_ctrl_pkg.sv ***
package pld_ctrl_pkg;
    // ----------------------------------------
    // Configuration image
    // ----------------------------------------
    localparam int unsigned BASE_FUSE_COUNT = 5892;
    localparam int unsigned PD_FUSE_COUNT = 5893;
    localparam int unsigned PD_FUSE_INDEX = 5892;
    localparam int unsigned SIG_BITS = 64;
    localparam int unsigned SIG_ADDR_W = 6;
    localparam logic [SIG_BITS-1:0] SIG_RESET = 64'h0000_0000_0000_0000;

    // ----------------------------------------
    // Programmer commands
    // ----------------------------------------
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_VERIFY,
        CMD_PRELOAD,
        CMD_SIG_READ,
        CMD_SIG_WRITE,
        CMD_SECURE
    } prog_cmd_e;

    typedef struct packed {
        logic valid;
        prog_cmd_e cmd;
        logic [SIG_ADDR_W-1:0] addr;
        logic data;
    } prog_req_s;

    typedef struct packed {
        logic valid;
        logic refused;
        logic data;
    } prog_rsp_s;
endpackage

// *** core/pin_keeper.sv ***
module pin_keeper
    import pld_ctrl_pkg::*;
#(
    parameter int unsigned WIDTH = 10
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] ext_drive,
    input wire logic [WIDTH-1:0] ext_level,
    input wire logic [WIDTH-1:0] own_oe_n,
    input wire logic [WIDTH-1:0] own_level,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] held_q;
    logic [WIDTH-1:0] held_d;

    // Own buffer wins over the external driver; with neither driving, hold last level
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_keep
            assign held_d[i] = !own_oe_n[i] ? own_level[i] :
                               ext_drive[i] ? ext_level[i] : held_q[i];
        end
    endgenerate

    // Keeper stays active in every mode, power-down included
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            held_q <= '0;
        end else begin
            held_q <= held_d;
        end
    end

    assign level = held_d;

    chk_keeper_holds: assert property (@(posedge core_clk) disable iff (!nrst)
        (own_oe_n[0] && !ext_drive[0]) |=> (held_q[0] == $past(held_q[0])))
        else $error("keeper lost level on undriven pin");
endmodule

// *** core/signature_store.sv ***
module signature_store
    import pld_ctrl_pkg::*;
#(
    parameter int unsigned BITS = SIG_BITS
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [SIG_ADDR_W-1:0] addr,
    input wire logic wr_data,
    output logic rd_data
);
    logic [BITS-1:0] sig_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sig_q <= SIG_RESET[BITS-1:0];
        end else if (wr_en) begin
            sig_q[addr] <= wr_data;
        end
    end

    // Readable regardless of security state
    assign rd_data = sig_q[addr];
endmodule

// *** core/pld_powerdown_security_ctrl.sv ***
module pld_powerdown_security_ctrl
    import pld_ctrl_pkg::*;
#(
    parameter int unsigned N_IN = 11,
    parameter int unsigned N_IO = 10
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic pd_fuse,
    input wire logic shared_input_powerdown_pin,
    input wire logic [N_IN-1:0] in_pins,
    input wire logic [N_IO-1:0] io_in,
    input wire logic [N_IO-1:0] io_ext_drive,
    input wire logic [N_IO-1:0] core_reg_d,
    input wire logic [N_IO-1:0] core_comb_d,
    input wire logic [N_IO-1:0] core_oe_n_d,
    input wire logic [N_IO-1:0] core_reg_sel,
    input wire logic [N_IO-1:0] cfg_verify_data,
    input wire prog_req_s prog_req,
    output prog_rsp_s prog_rsp,
    output logic secured,
    output logic power_down,
    output logic pd_as_input,
    output logic [N_IN-1:0] array_in,
    output logic [N_IO-1:0] array_io,
    output logic [N_IO-1:0] macro_reg,
    output logic [N_IO-1:0] io_out,
    output logic [N_IO-1:0] io_oe_n
);
    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    logic power_down_pin;
    logic run;
    logic [N_IN-1:0] in_hold_q;
    logic [N_IO-1:0] reg_q;
    logic [N_IO-1:0] reg_d;
    logic [N_IO-1:0] out_q;
    logic [N_IO-1:0] out_d;
    logic [N_IO-1:0] oe_n_q;
    logic [N_IO-1:0] oe_n_d;
    logic [N_IO-1:0] io_level;
    logic secured_q;
    logic preload_ok;
    logic verify_ok;
    logic sig_wr;
    logic sig_bit;
    prog_rsp_s rsp_q;
    prog_rsp_s rsp_d;

    assign power_down_pin = shared_input_powerdown_pin;
    assign power_down = pd_fuse && power_down_pin;
    assign run = !power_down;
    assign pd_as_input = !pd_fuse;

    // ----------------------------------------
    // Pin keepers
    // ----------------------------------------
    pin_keeper #(
        .WIDTH(N_IO)
    ) u_keeper (
        .core_clk(core_clk),
        .nrst(nrst),
        .ext_drive(io_ext_drive),
        .ext_level(io_in),
        .own_oe_n(oe_n_q),
        .own_level(out_q),
        .level(io_level)
    );

    // ----------------------------------------
    // Input gating
    // ----------------------------------------
    // Index 0 carries the shared pin; it feeds the array only when not a power-down pin
    logic [N_IN-1:0] in_live;
    assign in_live = {in_pins[N_IN-1:1], pd_fuse ? 1'b0 : shared_input_powerdown_pin};

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            in_hold_q <= '0;
        end else if (run) begin
            in_hold_q <= in_live;
        end
    end

    assign array_in = run ? in_live : in_hold_q;
    logic [N_IO-1:0] io_hold_q;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            io_hold_q <= '0;
        end else if (run) begin
            io_hold_q <= io_level;
        end
    end
    assign array_io = run ? io_level : io_hold_q;

    // ----------------------------------------
    // Macrocell registers, preload and freeze
    // ----------------------------------------
    assign preload_ok = prog_req.valid && prog_req.cmd == CMD_PRELOAD && !secured_q && run;

    genvar i;
    generate
        for (i = 0; i < N_IO; i++) begin : g_mc
            assign reg_d[i] = !run ? reg_q[i] :
                              (preload_ok && prog_req.addr == SIG_ADDR_W'(i)) ? prog_req.data :
                              core_reg_d[i];
        end
    endgenerate

    // Output and enable follow the core while running, frozen otherwise
    assign out_d = run ? ((core_reg_sel & reg_d) | (~core_reg_sel & core_comb_d)) : out_q;
    assign oe_n_d = run ? core_oe_n_d : oe_n_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            reg_q <= '0;
            out_q <= '0;
            oe_n_q <= '1;
        end else begin
            reg_q <= reg_d;
            out_q <= out_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign macro_reg = reg_q;
    assign io_out = out_q;
    assign io_oe_n = oe_n_q;

    // ----------------------------------------
    // Security fuse and programmer port
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            secured_q <= 1'b0;
        end else if (prog_req.valid && prog_req.cmd == CMD_SECURE) begin
            secured_q <= 1'b1;
        end
    end
    assign secured = secured_q;

    assign verify_ok = !secured_q;
    assign sig_wr = prog_req.valid && prog_req.cmd == CMD_SIG_WRITE;

    signature_store #(
        .BITS(SIG_BITS)
    ) u_sig (
        .core_clk(core_clk),
        .nrst(nrst),
        .wr_en(sig_wr),
        .addr(prog_req.addr),
        .wr_data(prog_req.data),
        .rd_data(sig_bit)
    );

    always_comb begin
        rsp_d = '0;
        rsp_d.valid = prog_req.valid && prog_req.cmd != CMD_NONE;
        unique case (prog_req.cmd)
            CMD_VERIFY: begin
                rsp_d.refused = !verify_ok;
                rsp_d.data = verify_ok && cfg_verify_data[prog_req.addr[3:0] % 4'(N_IO)];
            end
            CMD_PRELOAD: rsp_d.refused = secured_q || power_down;
            CMD_SIG_READ: rsp_d.data = sig_bit;
            CMD_NONE, CMD_SIG_WRITE, CMD_SECURE: rsp_d.refused = 1'b0;
            default: rsp_d.refused = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end
    assign prog_rsp = rsp_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_pd_hold;
        power_down ##1 power_down;
    endsequence

    chk_out_frozen: assert property (@(posedge core_clk) disable iff (!nrst)
        s_pd_hold |-> (io_out == $past(io_out)))
        else $error("output moved during power-down");
    chk_hiz_kept: assert property (@(posedge core_clk) disable iff (!nrst)
        s_pd_hold |-> (io_oe_n == $past(io_oe_n)))
        else $error("output enable moved during power-down");
    chk_undet_kept: assert property (@(posedge core_clk) disable iff (!nrst)
        (power_down && $past(power_down)) |-> $stable(out_q))
        else $error("output state changed in power-down");
    chk_reg_hold: assert property (@(posedge core_clk) disable iff (!nrst)
        power_down |=> (reg_q == $past(reg_q)))
        else $error("register changed in power-down");
    chk_input_block: assert property (@(posedge core_clk) disable iff (!nrst)
        s_pd_hold |-> (array_in == $past(array_in)) && (array_io == $past(array_io)))
        else $error("input reached array during power-down");
    chk_verify_refuse: assert property (@(posedge core_clk) disable iff (!nrst)
        (secured_q && prog_req.valid && prog_req.cmd == CMD_VERIFY) |=> (prog_rsp.refused && !prog_rsp.data))
        else $error("verify allowed while secured");
    chk_preload_refuse: assert property (@(posedge core_clk) disable iff (!nrst)
        (secured_q && prog_req.valid && prog_req.cmd == CMD_PRELOAD) |=> prog_rsp.refused)
        else $error("preload allowed while secured");
    chk_sig_open: assert property (@(posedge core_clk) disable iff (!nrst)
        (prog_req.valid && prog_req.cmd == CMD_SIG_READ) |=> (prog_rsp.valid && !prog_rsp.refused))
        else $error("signature read refused");
    chk_pd_option: assert property (@(posedge core_clk) disable iff (!nrst)
        !pd_fuse |-> (!power_down && array_in[0] == shared_input_powerdown_pin))
        else $error("shared pin not an input with option off");
    chk_resume: assert property (@(posedge core_clk) disable iff (!nrst)
        (!power_down && !preload_ok) |=> (reg_q == $past(core_reg_d)))
        else $error("registers did not resume");
endmodule

// *** bench/pd_source.sv ***
// ----------------------------------------
// External logic on the power-down pin
// ----------------------------------------
module pd_source (
    input wire logic core_clk,
    input wire logic want,
    input wire logic [3:0] lag,
    output logic shared_input_powerdown_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q = 4'h0;
    logic pin_q = 1'b0;

    assign shared_input_powerdown_pin = pin_q;

    // Follows the request on the falling edge after lag counted ones (lag+1 edges), so slow drivers are covered too
    always @(negedge core_clk) begin
        if (want == pin_q) begin
            cnt_q <= 4'h0;
        end else if (cnt_q >= lag) begin
            pin_q <= want;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// *** bench/tb_top.sv ***
module tb_top
    import pld_ctrl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic fuse;
        logic pin;
        logic [10:0] ins;
        logic [9:0] rd;
        logic [9:0] oe;
        logic [9:0] io;
        logic [9:0] out;
        logic pd;
        logic asin;
        logic [10:0] ain;
    } row_s;
    row_s rows[4] = '{
        '{1'b0, 1'b1, 11'h2AA, 10'h155, 10'h3FF, 10'h0F0, 10'h25A, 1'b0, 1'b1, 11'h2AB},
        '{1'b0, 1'b0, 11'h7FF, 10'h2AA, 10'h000, 10'h3C3, 10'h296, 1'b0, 1'b1, 11'h7FE},
        '{1'b1, 1'b0, 11'h555, 10'h3FF, 10'h0F0, 10'h0AA, 10'h0AA, 1'b0, 1'b0, 11'h554},
        '{1'b1, 1'b0, 11'h001, 10'h000, 10'h30F, 10'h3FF, 10'h000, 1'b0, 1'b0, 11'h000}};
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic pd_fuse = 1'b0;
    logic pd_want = 1'b0;
    logic [3:0] pd_lag = 4'h0;
    logic shared_input_powerdown_pin;
    logic [10:0] in_pins = 11'h000;
    logic [9:0] io_in = 10'h000, io_ext_drive = 10'h3FF, core_reg_d = 10'h000, core_comb_d = 10'h000;
    logic [9:0] core_oe_n_d = 10'h3FF, core_reg_sel = 10'h3FF, cfg_verify_data = 10'h204;
    prog_req_s prog_req = '0;
    prog_rsp_s prog_rsp;
    logic secured, power_down, pd_as_input;
    logic [10:0] array_in;
    logic [9:0] array_io, macro_reg, io_out, io_oe_n;
    int n_fail = 0, checks_done = 0, cycles = 0;

    always #12.5 core_clk = ~core_clk;

    pd_source far_end (.core_clk(core_clk), .want(pd_want), .lag(pd_lag),
        .shared_input_powerdown_pin(shared_input_powerdown_pin));

    pld_powerdown_security_ctrl dut (.core_clk(core_clk), .nrst(nrst), .pd_fuse(pd_fuse),
        .shared_input_powerdown_pin(shared_input_powerdown_pin), .in_pins(in_pins), .io_in(io_in),
        .io_ext_drive(io_ext_drive), .core_reg_d(core_reg_d), .core_comb_d(core_comb_d),
        .core_oe_n_d(core_oe_n_d), .core_reg_sel(core_reg_sel), .cfg_verify_data(cfg_verify_data),
        .prog_req(prog_req), .prog_rsp(prog_rsp), .secured(secured), .power_down(power_down),
        .pd_as_input(pd_as_input), .array_in(array_in), .array_io(array_io), .macro_reg(macro_reg),
        .io_out(io_out), .io_oe_n(io_oe_n));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Combinational path carries the inverse so that the output select is visible
    task automatic set_core(input logic [9:0] d, input logic [9:0] oe);
        core_reg_d = d;
        core_comb_d = ~d;
        core_oe_n_d = oe;
    endtask

    // Request stays up after return so back-to-back calls never touch it twice in one step
    task automatic prog(input prog_cmd_e c, input logic [5:0] a, input logic d, input logic er, input logic ed);
        prog_req = '{1'b1, c, a, d};
        step(1);
        chk("rsp_valid", prog_rsp.valid, 1'b1);
        chk("rsp_refused", prog_rsp.refused, er);
        if (c == CMD_VERIFY || c == CMD_SIG_READ) chk("rsp_data", prog_rsp.data, ed);
    endtask

    task automatic wait_pd(input logic v);
        repeat (8) if (power_down !== v) @(negedge core_clk);
        chk("power_down", power_down, v);
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 500) begin
            n_fail++;
            conclude();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        step(3);
        nrst = 1'b1;
        step(1);
        chk("fuse_count", PD_FUSE_COUNT - BASE_FUSE_COUNT, 64'h1);
        foreach (rows[i]) begin
            pd_fuse = rows[i].fuse;
            pd_want = rows[i].pin;
            in_pins = rows[i].ins;
            io_in = rows[i].io;
            core_reg_sel = rows[i].io;
            set_core(rows[i].rd, rows[i].oe);
            step(3);
            chk("power_down", power_down, rows[i].pd);
            chk("pd_as_input", pd_as_input, rows[i].asin);
            chk("array_in", array_in, rows[i].ain);
            chk("macro_reg", macro_reg, rows[i].rd);
            chk("io_out", io_out, rows[i].out);
            chk("io_oe_n", io_oe_n, rows[i].oe);
            chk("array_io", array_io, (rows[i].oe & rows[i].io) | (~rows[i].oe & rows[i].out));
        end
        // Keepers: external driver leaves, own buffer drives the low nibble
        set_core(10'h00F, 10'h3FF);
        io_in = 10'h2C5;
        step(3);
        core_oe_n_d = 10'h3F0;
        io_ext_drive = 10'h000;
        io_in = 10'h13A;
        step(3);
        chk("array_io", array_io, 10'h2CF);
        // Security fuse
        set_core(10'h000, 10'h3FF);
        step(2);
        prog(CMD_VERIFY, 6'h09, 1'b0, 1'b0, 1'b1);
        prog(CMD_VERIFY, 6'h0C, 1'b0, 1'b0, 1'b1);
        prog(CMD_SIG_WRITE, 6'h3F, 1'b1, 1'b0, 1'b0);
        prog(CMD_SIG_READ, 6'h3F, 1'b0, 1'b0, 1'b1);
        prog(CMD_SIG_READ, 6'h00, 1'b0, 1'b0, SIG_RESET[0]);
        prog(CMD_PRELOAD, 6'h02, 1'b1, 1'b0, 1'b0);
        chk("macro_reg", macro_reg, 10'h004);
        prog(CMD_SECURE, 6'h00, 1'b0, 1'b0, 1'b0);
        chk("secured", secured, 1'b1);
        prog(CMD_VERIFY, 6'h09, 1'b0, 1'b1, 1'b0);
        prog(CMD_PRELOAD, 6'h03, 1'b1, 1'b1, 1'b0);
        chk("macro_reg", macro_reg, 10'h000);
        prog(CMD_SIG_READ, 6'h3F, 1'b0, 1'b0, 1'b1);
        prog_req = '0;
        nrst = 1'b0;
        step(1);
        chk("secured", secured, 1'b0);
        nrst = 1'b1;
        step(1);
        prog(CMD_VERIFY, 6'h09, 1'b0, 1'b0, 1'b1);
        prog_req = '0;
        // Power-down with a slow driver, then inputs move while frozen
        pd_fuse = 1'b1;
        io_ext_drive = 10'h3FF;
        io_in = 10'h155;
        in_pins = 11'h3CE;
        set_core(10'h0A5, 10'h0FF);
        step(3);
        pd_lag = 4'h2;
        pd_want = 1'b1;
        wait_pd(1'b1);
        step(1);
        set_core(10'h35A, 10'h300);
        io_in = 10'h0AA;
        in_pins = 11'h431;
        io_ext_drive = 10'h000;
        prog(CMD_PRELOAD, 6'h01, 1'b1, 1'b1, 1'b0);
        prog_req = '0;
        step(3);
        chk("array_in", array_in, 11'h3CE);
        chk("array_io", array_io, 10'h055);
        chk("macro_reg", macro_reg, 10'h0A5);
        chk("io_out", io_out, 10'h0A5);
        chk("io_oe_n", io_oe_n, 10'h0FF);
        pd_lag = 4'h0;
        pd_want = 1'b0;
        wait_pd(1'b0);
        step(2);
        chk("array_in", array_in, 11'h430);
        chk("macro_reg", macro_reg, 10'h35A);
        chk("io_oe_n", io_oe_n, 10'h300);
        chk("array_io", array_io, 10'h05A);
        conclude();
    end
endmodule
